// ### design/acs_period_timer.sv
// counts output-rate periods and master clock periods
`timescale 1ns/100ps
`default_nettype none
module acs_period_timer #(
    parameter int W = 12
) (
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic         load,
    input  wire logic [W-1:0] count,
    input  wire logic         tick,
    output logic              done
);
    logic [W-1:0] left_r;
    logic         run_r;

    // ----------------------------------------------------------------
    // down counter, done fires when the last tick is taken
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            left_r <= '0;
            run_r  <= 1'b0;
        end else if (load) begin
            left_r <= count;
            run_r  <= (count != '0);
        end else if (run_r && tick) begin
            left_r <= left_r - 1'b1;
            if (left_r == {{(W-1){1'b0}}, 1'b1}) begin
                run_r <= 1'b0;
            end
        end
    end

    assign done = run_r && tick && (left_r == {{(W-1){1'b0}}, 1'b1});
endmodule
`default_nettype wire

// ### design/acs_pkg.sv
// types shared by the calibration sequencer
package acs_pkg;
    typedef enum logic [4:0] {
        ACS_IDLE = 5'b00001,
        ACS_ZERO_STEP = 5'b00010,
        ACS_FULL_STEP = 5'b00100,
        ACS_CONV      = 5'b01000,
        ACS_PIPE      = 5'b10000
    } acs_state_t;

    typedef struct packed {
        logic op_select_hi;
        logic op_select_lo;
    } acs_mode_t;
endpackage

// ### design/acs_regs.svh
// timing and field constants for the calibration sequencer
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH

// ----------------------------------------------------------------
// mode field codes
// ----------------------------------------------------------------
`define ACS_MODE_NORMAL       2'h0
`define ACS_MODE_SELF_CAL     2'h1
`define ACS_MODE_ZERO_SYS_CAL 2'h2
`define ACS_MODE_FULL_SYS_CAL 2'h3

// ----------------------------------------------------------------
// durations in output-rate periods
// ----------------------------------------------------------------
`define ACS_SELF_CAL_PERIODS 4'h6
`define ACS_SELF_RDY_PERIODS 4'h9
`define ACS_SYS_CAL_PERIODS  4'h3
`define ACS_SYS_RDY_PERIODS  4'h4

// ----------------------------------------------------------------
// pipeline delay, in master clock periods
// ----------------------------------------------------------------
`define ACS_PIPE_MAX_MCLK    2000
`define ACS_PIPE_DEF_MCLK    12'h7d0

`endif

// ### design/acs_sequencer.sv
// calibration sequencer: zero-scale and full-scale steps, conversion, ready flag
`include "acs_regs.svh"
`timescale 1ns/100ps
`default_nettype none
// How it works
// RULE_01: ready falls low when sequence ends
// RULE_02: automatic normal conversion follows calibration steps
// RULE_03: mode field returns to zero at completion
// RULE_04: mode clears before ready, implies no data
// RULE_05: mode clears after calibration steps only
// RULE_06: ready after calibration, conversion, pipeline delay
// RULE_07: pipeline delay at most 2000 master clocks
// RULE_08: code 01 self cal, 6 and 9 periods
// RULE_09: code 10 zero system cal, 3 and 4
// RULE_10: code 11 full system cal, 3 and 4
// RULE_11: host writes nonzero code, then waits completion
module acs_sequencer #(
    parameter int PIPE_MCLK = 2000
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             mclk_tick,
    input  wire logic             rate_tick,
    input  wire logic             mode_wr,
    input  wire acs_pkg::acs_mode_t mode_wdata,
    input  wire logic [15:0]      conv_result,
    output acs_pkg::acs_mode_t    mode_field,
    output logic                  zero_scale,
    output logic                  full_scale,
    output logic                  internal_ref,
    output logic                  cal_busy,
    output logic [15:0]           data_reg,
    output logic                  result_valid_n
);
    acs_pkg::acs_state_t state_r;
    acs_pkg::acs_state_t state_nxt;
    acs_pkg::acs_mode_t  mode_r;
    logic [1:0]          cmd;
    logic                cmd_take;
    logic [3:0]          full_len;
    logic [3:0]          conv_len;
    logic                per_load;
    logic [11:0]         per_count;
    logic                per_done;
    logic                pipe_load;
    logic                pipe_done;
    logic                rdy_n_r;

    // delay clipped so it can never pass the bound
    localparam logic [11:0] PIPE_LEN = (PIPE_MCLK > `ACS_PIPE_MAX_MCLK) ?
        `ACS_PIPE_DEF_MCLK : 12'(PIPE_MCLK); // RULE_07

    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    function automatic logic is_cal_cmd(input acs_pkg::acs_mode_t code);
        return {code.op_select_hi, code.op_select_lo} != `ACS_MODE_NORMAL;
    endfunction

    // first step length comes from the write, the field is not loaded yet
    function automatic logic [11:0] first_len(input acs_pkg::acs_mode_t code);
        logic [11:0] len;
        len = 12'(`ACS_SELF_CAL_PERIODS >> 1); // RULE_08
        if (code.op_select_hi) begin
            len = 12'(`ACS_SYS_CAL_PERIODS); // RULE_09 RULE_10
        end
        return len;
    endfunction

    assign cmd = {mode_r.op_select_hi, mode_r.op_select_lo};
    // writes while busy are dropped without a trace
    assign cmd_take = mode_wr && (state_r == acs_pkg::ACS_IDLE) && is_cal_cmd(mode_wdata);

    // ----------------------------------------------------------------
    // step lengths per mode
    // ----------------------------------------------------------------
    always_comb begin
        full_len = 4'h0;
        conv_len = 4'h0;
        unique case (cmd)
            `ACS_MODE_SELF_CAL: begin
                // self steps split the six periods evenly
                full_len = `ACS_SELF_CAL_PERIODS >> 1; // RULE_08
                conv_len = `ACS_SELF_RDY_PERIODS - `ACS_SELF_CAL_PERIODS; // RULE_08
            end
            `ACS_MODE_ZERO_SYS_CAL: begin
                conv_len = `ACS_SYS_RDY_PERIODS - `ACS_SYS_CAL_PERIODS; // RULE_09
            end
            `ACS_MODE_FULL_SYS_CAL: begin
                full_len = `ACS_SYS_CAL_PERIODS; // RULE_10
                conv_len = `ACS_SYS_RDY_PERIODS - `ACS_SYS_CAL_PERIODS; // RULE_10
            end
            `ACS_MODE_NORMAL: begin
            end
        endcase
    end

    // ----------------------------------------------------------------
    // sequence state
    // ----------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        per_load  = 1'b0;
        per_count = 12'h0;
        pipe_load = 1'b0;
        unique case (state_r)
            acs_pkg::ACS_IDLE: begin
                if (cmd_take) begin
                    per_load  = 1'b1;
                    per_count = first_len(mode_wdata);
                    state_nxt = (mode_wdata == `ACS_MODE_FULL_SYS_CAL) ?
                                acs_pkg::ACS_FULL_STEP : acs_pkg::ACS_ZERO_STEP;
                end
            end
            acs_pkg::ACS_ZERO_STEP: begin
                if (per_done) begin
                    per_load = 1'b1;
                    if (full_len != 4'h0) begin
                        per_count = 12'(full_len);
                        state_nxt = acs_pkg::ACS_FULL_STEP;
                    end else begin
                        per_count = 12'(conv_len); // RULE_02
                        state_nxt = acs_pkg::ACS_CONV;
                    end
                end
            end
            acs_pkg::ACS_FULL_STEP: begin
                if (per_done) begin
                    per_load  = 1'b1;
                    per_count = 12'(conv_len); // RULE_02
                    state_nxt = acs_pkg::ACS_CONV;
                end
            end
            acs_pkg::ACS_CONV: begin
                if (per_done) begin
                    pipe_load = 1'b1;
                    state_nxt = acs_pkg::ACS_PIPE; // RULE_06
                end
            end
            acs_pkg::ACS_PIPE: begin
                // zero delay leaves at once, the timer never runs
                if (pipe_done || PIPE_LEN == 12'h0) begin
                    state_nxt = acs_pkg::ACS_IDLE;
                end
            end
            default: begin
                state_nxt = acs_pkg::ACS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_r <= acs_pkg::ACS_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ----------------------------------------------------------------
    // mode field: set by host write, cleared when steps end
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mode_r <= 2'h0;
        end else if (state_r == acs_pkg::ACS_IDLE && mode_wr) begin
            // a zero write while idle just rewrites zero
            mode_r <= mode_wdata; // RULE_11
        end else if (state_nxt == acs_pkg::ACS_CONV &&
                     state_r != acs_pkg::ACS_CONV) begin
            mode_r <= 2'h0; // RULE_03 RULE_05
        end
    end

    // ----------------------------------------------------------------
    // result register and ready flag
    // ----------------------------------------------------------------
    // data only latched at the end, so a mode poll sees stale data
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            data_reg <= 16'h0;
            rdy_n_r  <= 1'b1;
        end else if (state_r == acs_pkg::ACS_PIPE &&
                     state_nxt == acs_pkg::ACS_IDLE) begin
            data_reg <= conv_result; // RULE_04
            rdy_n_r  <= 1'b0; // RULE_01
        end else if (cmd_take) begin
            rdy_n_r <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // period timers
    // ----------------------------------------------------------------
    // load wins over tick, so a step never eats the tick that ended the last
    acs_period_timer #(.W(12)) u_rate (
        .clock (clock),
        .rst   (rst),
        .load  (per_load),
        .count (per_count),
        .tick  (rate_tick),
        .done  (per_done)
    );

    acs_period_timer #(.W(12)) u_pipe (
        .clock (clock),
        .rst   (rst),
        .load  (pipe_load),
        .count (PIPE_LEN),
        .tick  (mclk_tick),
        .done  (pipe_done)
    );

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign mode_field     = mode_r;
    assign zero_scale     = (state_r == acs_pkg::ACS_ZERO_STEP);
    assign full_scale     = (state_r == acs_pkg::ACS_FULL_STEP);
    assign internal_ref   = (cmd == `ACS_MODE_SELF_CAL);
    assign cal_busy       = (state_r != acs_pkg::ACS_IDLE);
    assign result_valid_n = rdy_n_r;
endmodule
`default_nettype wire

// ### tb/acs_host_model.sv
// host model that writes the mode field
`timescale 1ns/100ps
`default_nettype none
module acs_host_model (
    input wire logic          clock,
    input wire logic          go,
    input wire logic [1:0]    code,
    output var logic          mode_wr,
    output acs_pkg::acs_mode_t mode_wdata
);
    initial begin
        mode_wr = 1'b0;
        mode_wdata = 2'h0;
    end
    // falling edge keeps the write clear of the sampling edge
    always @(negedge clock) begin
        mode_wr <= go;
        mode_wdata <= code;
    end
endmodule
`default_nettype wire

// ### tb/acs_sequencer_checker.sv
// assertions for the calibration sequencer
`timescale 1ns/100ps
`default_nettype none
module acs_sequencer_checker #(
    parameter int PIPE_MCLK = 2000
) (
    input wire logic               clock,
    input wire logic               rst,
    input wire logic               mclk_tick,
    input wire logic               rate_tick,
    input wire logic               mode_wr,
    input wire acs_pkg::acs_mode_t mode_wdata,
    input wire logic [15:0]        conv_result,
    input wire acs_pkg::acs_mode_t mode_field,
    input wire logic               zero_scale,
    input wire logic               full_scale,
    input wire logic               internal_ref,
    input wire logic               cal_busy,
    input wire logic [15:0]        data_reg,
    input wire logic               result_valid_n
);
    // ------------------------------------------------------------
    // tick counts since the accepted command
    // ------------------------------------------------------------
    localparam logic [11:0] PIPE_EXP = (PIPE_MCLK > 2000) ? 12'h7d0 : 12'(PIPE_MCLK);
    logic [3:0]  rt_r;
    logic [11:0] mt_r;
    logic        self_r;
    wire logic [3:0] tot = self_r ? 4'h9 : 4'h4;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rt_r <= 4'h0;
            mt_r <= 12'h0;
            self_r <= 1'b0;
        end else if (mode_wr && !cal_busy && |mode_wdata) begin
            rt_r <= 4'h0;
            mt_r <= 12'h0;
            self_r <= (mode_wdata == 2'h1);
        end else if (cal_busy) begin
            if (rate_tick && rt_r != tot) rt_r <= rt_r + 4'h1;
            if (mclk_tick && rt_r == tot) mt_r <= mt_r + 12'h1;
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_done;
        !result_valid_n && !cal_busy && mode_field == 2'h0;
    endsequence
    property p_rdy; $fell(result_valid_n) |-> s_done; endproperty
    property p_data; $fell(result_valid_n) |-> data_reg == $past(conv_result); endproperty
    property p_clr; $fell(|mode_field) |-> rt_r == (self_r ? 4'h6 : 4'h3); endproperty
    property p_early; $fell(|mode_field) |-> result_valid_n [*2]; endproperty
    property p_time; $fell(result_valid_n) |-> rt_r == tot && mt_r == PIPE_EXP;
    endproperty
    property p_bound; cal_busy && rt_r == tot |-> mt_r <= 12'h7d0; endproperty
    property p_self;
        mode_field == 2'h1 |-> internal_ref && (rt_r < 4'h3 ? zero_scale : full_scale);
    endproperty
    property p_sys;
        mode_field.op_select_hi |->
            zero_scale == !mode_field.op_select_lo && full_scale == mode_field.op_select_lo;
    endproperty
    a_rdy: assert property (p_rdy) else $error("ready fell outside a finished sequence");
    a_data: assert property (p_data) else $error("data not loaded at ready");
    a_clr: assert property (p_clr) else $error("mode cleared after wrong tick count");
    a_early: assert property (p_early) else $error("mode clear not ahead of ready");
    a_time: assert property (p_time) else $error("ready fell at wrong time");
    a_bound: assert property (p_bound) else $error("pipeline delay too long");
    a_self: assert property (p_self) else $error("self step order wrong");
    a_sys: assert property (p_sys) else $error("system step wrong");
endmodule
bind acs_sequencer acs_sequencer_checker #(.PIPE_MCLK(PIPE_MCLK)) u_chk (.clock, .rst,
    .mclk_tick, .rate_tick, .mode_wr, .mode_wdata, .conv_result, .mode_field, .zero_scale,
    .full_scale, .internal_ref, .cal_busy, .data_reg, .result_valid_n);
`default_nettype wire

// ### tb/test_acs_sequencer.sv
// self-checking testbench for the calibration sequencer
`timescale 1ns/100ps
`default_nettype none
module test_acs_sequencer;
    localparam int PIPE = 5;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic go = 1'b0;
    logic [1:0] code = 2'h0;
    logic [2:0] ph = 3'h0;
    logic [15:0] conv = 16'h0;
    logic [15:0] held = 16'h0;
    logic [3:0] nt = 4'h0;
    logic [3:0] er = 4'h4;
    logic [11:0] nm = 12'h0;
    int bad_count = 0;
    int check_count = 0;
    logic mode_wr, busy, rdy_n;
    logic [15:0] dreg;
    acs_pkg::acs_mode_t wdata, mode;
    // rows: code, ticks to mode clear, ticks to ready
    logic [9:0] rows [3] = '{10'h169, 10'h234, 10'h334};
    always #5 clock = ~clock;
    // rate tick at phase zero only, master tick at odd phases
    always @(negedge clock) ph <= ph + 3'h1;
    always @(posedge clock) begin
        nt <= (mode_wr && !busy) ? 4'h0 : nt + {3'h0, ph == 3'h0 && nt != er};
        nm <= (mode_wr && !busy) ? 12'h0 : nm + {11'h0, ph[0] && nt == er};
    end
    acs_host_model host (.clock(clock), .go(go), .code(code), .mode_wr(mode_wr),
        .mode_wdata(wdata));
    acs_sequencer #(.PIPE_MCLK(PIPE)) dut (.clock(clock), .rst(rst), .mclk_tick(ph[0]),
        .rate_tick(ph == 3'h0), .mode_wr(mode_wr), .mode_wdata(wdata), .conv_result(conv),
        .mode_field(mode), .zero_scale(), .full_scale(), .internal_ref(), .cal_busy(busy),
        .data_reg(dreg), .result_valid_n(rdy_n));
    task chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task tally_and_finish;
        if (bad_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task host_write(input logic [1:0] c);
        @(posedge clock) go <= 1'b1;
        code <= c;
        @(posedge clock) go <= 1'b0;
    endtask
    task run(input logic [9:0] row);
        logic cleared;
        cleared = 1'b0;
        @(negedge clock);
        er = row[3:0];
        conv = {row, 6'h2a};
        host_write(row[9:8]);
        for (int i = 0; i < 300; i++) begin
            @(negedge clock);
            if (mode === 2'h0 && !cleared) begin
                cleared = 1'b1;
                chk(nt, row[7:4], "clear ticks");
                chk(rdy_n, 1'b1, "early ready");
                chk(dreg, held, "stale data");
                conv = {row, 6'h15};
            end
            if (rdy_n === 1'b0) break;
        end
        chk({15'h0, cleared}, 16'h1, "mode cleared");
        chk(rdy_n, 1'b0, "ready");
        chk(nt, row[3:0], "ready ticks");
        chk(nm, 16'(PIPE), "pipe ticks");
        chk(dreg, conv, "data");
        held = conv;
    endtask
    initial begin
        repeat (4) @(negedge clock);
        chk({mode, rdy_n, busy}, 16'h2, "reset");
        rst = 1'b0;
        foreach (rows[i]) run(rows[i]);
        host_write(2'h0);
        @(negedge clock);
        chk({busy, rdy_n}, 16'h0, "zero code");
        host_write(2'h2);
        host_write(2'h1);
        @(negedge clock);
        chk(mode, 2'h2, "write while busy");
        chk({15'h0, busy}, 16'h1, "busy kept");
        rst = 1'b1;
        @(negedge clock);
        chk({mode, rdy_n, busy}, 16'h2, "mid reset");
        chk(dreg, 16'h0, "mid reset data");
        held = 16'h0;
        rst = 1'b0;
        run(rows[2]);
        tally_and_finish;
    end
    // all runs need well under a thousand cycles
    initial begin
        #200000;
        bad_count++;
        tally_and_finish;
    end
endmodule
`default_nettype wire
